// *** usps_defs.svh ***
// constants for the usb status and pin function block
`ifndef USPS_DEFS_SVH
`define USPS_DEFS_SVH
`define USPS_CLK_HZ 125000000
`define USPS_BLINK_HZ 10
// half period of a 10 hz toggle in core cycles
`define USPS_BLINK_HALF_CYC (`USPS_CLK_HZ / (2 * `USPS_BLINK_HZ))
`define USPS_ONE_UNIT_LOAD 8'h32
`define USPS_SEL_RESET_BIT 0
`define USPS_SEL_SUSP_BIT 1
`define USPS_SEL_CURR_BIT 2
`define USPS_SEL_POL_BIT 3
// active high, suspend only
`define USPS_SEL_A_RST 4'h2
// active low, suspend only
`define USPS_SEL_B_RST 4'ha
`define USPS_NUM_PINS 10
`define USPS_FUNC_RST 3'h0
`define USPS_FUNC_GPIO_IN 3'h0
`define USPS_FUNC_GPIO_OUT 3'h1
`define USPS_FUNC_ALT 3'h2
`define USPS_FUNC_ALT2 3'h3
`define USPS_WAKE_PULSE_CYC 16'h0001
`endif

// *** usps_pkg.sv ***
// types for the usb status and pin function block
package usps_pkg;
    typedef struct packed {
        logic bus_reset;
        logic suspended;
        logic configured;
        logic [7:0] max_power;
    } usps_usb_state_t;

    typedef struct packed {
        logic active_low;
        logic use_current;
        logic use_suspend;
        logic use_reset;
    } usps_cond_sel_t;

    typedef enum logic [1:0] {
        USPS_BLINK_IDLE,
        USPS_BLINK_RUN
    } usps_blink_state_t;
endpackage

// *** usps_blink.sv ***
// activity blinker toggling at about 10 hz while busy
`timescale 1ns/1ps
`include "usps_defs.svh"
module usps_blink
    import usps_pkg::*;
#(
    parameter int HALF_CYC = `USPS_BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // activity
    input wire logic busy_in,
    // indicator level
    output logic blink_out
);
    usps_blink_state_t state_q;
    logic [31:0] cnt_q;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= USPS_BLINK_IDLE;
            cnt_q <= 32'h0;
            blink_out <= 1'b1;
        end else begin
            case (state_q)
                USPS_BLINK_IDLE: begin
                    cnt_q <= 32'h0;
                    blink_out <= 1'b1;
                    if (busy_in) begin
                        state_q <= USPS_BLINK_RUN;
                    end
                end
                USPS_BLINK_RUN: begin
                    if (cnt_q >= HALF_CYC[31:0] - 32'h1) begin
                        cnt_q <= 32'h0;
                        blink_out <= ~blink_out;
                        if (!busy_in) begin
                            state_q <= USPS_BLINK_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= USPS_BLINK_IDLE;
                end
            endcase
        end
    end
endmodule

// *** usps_top.sv ***
// usb status outputs and multifunction channel pin behaviour
// Contract
// - status output can assert during host-driven bus reset.
// - status output can assert while device is suspended.
// - current condition, max power at most 0x32: asserted only when suspended.
// - current condition, max power above 0x32: suspended or not configured.
// - settings choose polarity and which conditions drive status output.
// - output inactive whenever no selected condition holds.
// - first output resets active high reporting suspend only.
// - channel pins reset as inputs with pull-up enabled.
// - falling edge on wakeup-configured ring pin requests remote wakeup.
// - receive indicator toggles near 10 hz while receiving.
// - request-to-send is active-low flow output or rs-485 direction.
// - clear-to-send is active-low input sampled for flow control.
// - terminal-ready is active-low push-pull output when selected.
// - second output like first, default active low on suspend.
// - transmit indicator toggles near 10 hz while transmitting.
`timescale 1ns/1ps
`include "usps_defs.svh"
module usps_top
    import usps_pkg::*;
#(
    parameter int BLINK_HALF_CYC = `USPS_BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // usb engine state
    input wire usps_usb_state_t usb_state_in,
    // status output selections
    input wire logic cfg_sel_a_we_in,
    input wire logic cfg_sel_b_we_in,
    input wire usps_cond_sel_t cfg_sel_in,
    // pin function selection, one write per pin
    input wire logic cfg_func_we_in,
    input wire logic [3:0] cfg_func_idx_in,
    input wire logic [2:0] cfg_func_in,
    input wire logic [9:0] gpio_out_val_in,
    // uart side activity and flow control
    input wire logic uart_rx_busy_in,
    input wire logic uart_tx_busy_in,
    input wire logic uart_tx_active_in,
    input wire logic flow_rts_assert_in,
    input wire logic flow_dtr_assert_in,
    // channel pins
    input wire logic [9:0] pin_in,
    output logic [9:0] pin_out,
    output logic [9:0] pin_oe_out,
    output logic [9:0] pin_pullup_out,
    // status pins
    output logic usb_condition_out_a,
    output logic usb_condition_out_b,
    // decoded modem inputs, active high, then raw level of the wake pin
    output logic clear_send_out,
    output logic set_ready_out,
    output logic carrier_detect_out,
    output logic ring_indicate_out,
    output logic gpio_in_val_out,
    // wakeup request pulse
    output logic remote_wakeup_req_out
);
    // pin positions within the channel
    localparam int P_WAKE = 0;
    localparam int P_CD = 1;
    localparam int P_DSR = 2;
    localparam int P_DTR = 3;
    localparam int P_CTS = 4;
    localparam int P_RTS = 5;
    localparam int P_DIR = 7;
    localparam int P_TXB = 8;
    localparam int P_RXB = 9;

    usps_cond_sel_t sel_a_q;
    usps_cond_sel_t sel_b_q;
    logic [2:0] func_q [`USPS_NUM_PINS];
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [9:0] prev_q;
    logic rx_blink;
    logic tx_blink;
    logic [9:0] drv_d;
    logic [9:0] oe_d;

    // status condition decode shared by both status pins
    function automatic logic cond_eval(input usps_cond_sel_t sel, input usps_usb_state_t st);
        logic hit;
        logic unsafe;
        hit = 1'b0;
        unsafe = st.suspended;
        if (st.max_power > `USPS_ONE_UNIT_LOAD) begin
            unsafe = st.suspended | ~st.configured;
        end
        hit = (sel.use_reset & st.bus_reset)
            | (sel.use_suspend & st.suspended)
            | (sel.use_current & unsafe);
        cond_eval = hit ^ sel.active_low;
    endfunction

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_a_q <= `USPS_SEL_A_RST;
            sel_b_q <= `USPS_SEL_B_RST;
        end else begin
            if (cfg_sel_a_we_in) begin
                sel_a_q <= cfg_sel_in;
            end
            if (cfg_sel_b_we_in) begin
                sel_b_q <= cfg_sel_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            usb_condition_out_a <= 1'b0;
            usb_condition_out_b <= 1'b1;
        end else begin
            usb_condition_out_a <= cond_eval(sel_a_q, usb_state_in);
            usb_condition_out_b <= cond_eval(sel_b_q, usb_state_in);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `USPS_NUM_PINS; gi++) begin : g_func
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    func_q[gi] <= `USPS_FUNC_RST;
                end else if (cfg_func_we_in && cfg_func_idx_in == 4'(gi)) begin
                    func_q[gi] <= cfg_func_in;
                end
            end
        end
    endgenerate

    // two-stage synchroniser, then one history stage
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= 10'h3ff;
            sync2_q <= 10'h3ff;
            prev_q <= 10'h3ff;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    usps_blink #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_rx_blink (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .busy_in(uart_rx_busy_in),
        .blink_out(rx_blink)
    );

    usps_blink #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_tx_blink (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .busy_in(uart_tx_busy_in),
        .blink_out(tx_blink)
    );

    // pin drive selection
    always_comb begin
        drv_d = 10'h0;
        oe_d = 10'h0;
        for (int i = 0; i < `USPS_NUM_PINS; i++) begin
            drv_d[i] = gpio_out_val_in[i];
            oe_d[i] = (func_q[i] == `USPS_FUNC_GPIO_OUT);
        end
        if (func_q[P_RTS] == `USPS_FUNC_ALT) begin
            drv_d[P_RTS] = ~flow_rts_assert_in;
            oe_d[P_RTS] = 1'b1;
        end else if (func_q[P_RTS] == `USPS_FUNC_ALT2) begin
            drv_d[P_RTS] = uart_tx_active_in;
            oe_d[P_RTS] = 1'b1;
        end
        if (func_q[P_DIR] == `USPS_FUNC_ALT) begin
            drv_d[P_DIR] = uart_tx_active_in;
            oe_d[P_DIR] = 1'b1;
        end
        if (func_q[P_DTR] == `USPS_FUNC_ALT) begin
            drv_d[P_DTR] = ~flow_dtr_assert_in;
            oe_d[P_DTR] = 1'b1;
        end
        if (func_q[P_RXB] == `USPS_FUNC_ALT) begin
            drv_d[P_RXB] = rx_blink;
            oe_d[P_RXB] = 1'b1;
        end
        if (func_q[P_TXB] == `USPS_FUNC_ALT) begin
            drv_d[P_TXB] = tx_blink;
            oe_d[P_TXB] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= 10'h0;
            pin_oe_out <= 10'h0;
            pin_pullup_out <= 10'h3ff;
        end else begin
            pin_out <= drv_d;
            pin_oe_out <= oe_d;
            for (int i = 0; i < `USPS_NUM_PINS; i++) begin
                pin_pullup_out[i] <= (func_q[i] == `USPS_FUNC_GPIO_IN);
            end
        end
    end

    // modem inputs decoded only when their function is selected
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clear_send_out <= 1'b0;
            set_ready_out <= 1'b0;
            carrier_detect_out <= 1'b0;
            ring_indicate_out <= 1'b0;
            gpio_in_val_out <= 1'b1;
        end else begin
            clear_send_out <= (func_q[P_CTS] == `USPS_FUNC_ALT) & ~sync2_q[P_CTS];
            set_ready_out <= (func_q[P_DSR] == `USPS_FUNC_ALT) & ~sync2_q[P_DSR];
            carrier_detect_out <= (func_q[P_CD] == `USPS_FUNC_ALT) & ~sync2_q[P_CD];
            ring_indicate_out <= (func_q[P_WAKE] == `USPS_FUNC_ALT) & ~sync2_q[P_WAKE];
            gpio_in_val_out <= sync2_q[P_WAKE];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            remote_wakeup_req_out <= 1'b0;
        end else begin
            remote_wakeup_req_out <= (func_q[P_WAKE] == `USPS_FUNC_ALT2)
                & prev_q[P_WAKE] & ~sync2_q[P_WAKE];
        end
    end
endmodule

// *** usps_top_properties.sv ***
// assertion checker for the usb status and pin function block
`timescale 1ns/1ps
`include "usps_defs.svh"
module usps_top_chk
    import usps_pkg::*;
(
    // clock, reset and inputs
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire usps_usb_state_t usb_state_in,
    input wire logic cfg_sel_a_we_in,
    input wire logic cfg_sel_b_we_in,
    input wire usps_cond_sel_t cfg_sel_in,
    input wire logic [9:0] pin_in,
    // outputs
    input wire logic [9:0] pin_oe_out,
    input wire logic [9:0] pin_pullup_out,
    input wire logic usb_condition_out_a,
    input wire logic usb_condition_out_b,
    input wire logic clear_send_out,
    input wire logic set_ready_out,
    input wire logic ring_indicate_out,
    input wire logic remote_wakeup_req_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    usps_cond_sel_t sel_a_q;
    usps_cond_sel_t sel_b_q;
    logic [1:0] up_q;
    function automatic logic want(usps_cond_sel_t s, usps_usb_state_t u);
        logic unsafe;
        unsafe = u.suspended | ((u.max_power > 8'h32) & ~u.configured);
        return ((s.use_reset & u.bus_reset) | (s.use_suspend & u.suspended) | (s.use_current & unsafe)) ^ s.active_low;
    endfunction
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_a_q <= `USPS_SEL_A_RST;
            sel_b_q <= `USPS_SEL_B_RST;
        end else begin
            if (cfg_sel_a_we_in) sel_a_q <= cfg_sel_in;
            if (cfg_sel_b_we_in) sel_b_q <= cfg_sel_in;
        end
    end
    // edges seen since reset, saturating
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    a_status_a_follows: assert property (up_q == 2'h3 |->
        usb_condition_out_a == want($past(sel_a_q), $past(usb_state_in))) else $error("status a wrong");
    a_status_b_follows: assert property (up_q == 2'h3 |->
        usb_condition_out_b == want($past(sel_b_q), $past(usb_state_in))) else $error("status b wrong");
    a_pins_come_up: assert property (up_q == 2'h1 |->
        pin_oe_out == 10'h000 && pin_pullup_out == 10'h3ff) else $error("pins not inputs with pull-up");
    a_wake_one_cycle: assert property (remote_wakeup_req_out |=> !remote_wakeup_req_out)
        else $error("wakeup pulse too long");
    a_wake_after_fall: assert property ($rose(remote_wakeup_req_out) |->
        !$past(pin_in[0], 3) && $past(pin_in[0], 4)) else $error("wakeup without falling edge");
    a_cts_pin_low: assert property (clear_send_out |-> !$past(pin_in[4], 3))
        else $error("clear to send without low pin");
    a_dsr_pin_low: assert property (set_ready_out |-> !$past(pin_in[2], 3))
        else $error("set ready without low pin");
    a_ring_pin_low: assert property (ring_indicate_out |-> !$past(pin_in[0], 3))
        else $error("ring without low pin");
    c_wake: cover property ($rose(remote_wakeup_req_out));
    c_status_a: cover property ($rose(usb_condition_out_a));
    c_cts: cover property ($rose(clear_send_out));
endmodule
bind usps_top usps_top_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .usb_state_in(usb_state_in),
    .cfg_sel_a_we_in(cfg_sel_a_we_in), .cfg_sel_b_we_in(cfg_sel_b_we_in), .cfg_sel_in(cfg_sel_in),
    .pin_in(pin_in), .pin_oe_out(pin_oe_out), .pin_pullup_out(pin_pullup_out),
    .usb_condition_out_a(usb_condition_out_a), .usb_condition_out_b(usb_condition_out_b),
    .clear_send_out(clear_send_out), .set_ready_out(set_ready_out), .ring_indicate_out(ring_indicate_out),
    .remote_wakeup_req_out(remote_wakeup_req_out));

// *** usps_peer.sv ***
// serial peer model resolving the channel pin levels
`timescale 1ns/1ps
module usps_peer (
    // device pin drive
    input wire logic [9:0] dev_val_in,
    input wire logic [9:0] dev_oe_in,
    input wire logic [9:0] dev_pu_in,
    // lines the peer pulls low
    input wire logic [9:0] low_in,
    output logic [9:0] level_out
);
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (dev_oe_in[i])
                level_out[i] = dev_val_in[i];
            else if (low_in[i])
                level_out[i] = 1'b0;
            else
                level_out[i] = dev_pu_in[i] | ~dev_val_in[i];
        end
    end
endmodule

// *** usps_top_tb.sv ***
// testbench for the usb status and pin function block
`timescale 1ns/1ps
module usps_top_tb;
    import usps_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    usps_usb_state_t usb = '0;
    usps_cond_sel_t sel = '0;
    usps_usb_state_t tab [5];
    logic we_a = 1'b0, we_b = 1'b0, fwe = 1'b0, rxb = 1'b0, txb = 1'b0, txa = 1'b0, rts = 1'b0, dtr = 1'b0;
    logic [3:0] fidx = '0;
    logic [2:0] fcode = '0;
    logic [9:0] gval = '0, low = '0, lvl, p_out, p_oe, p_pu;
    logic st_a, st_b, cts, dsr, cd, ri, gin, wake;
    int n_errors = 0, check_count = 0, nwake = 0, n9, n8;
    logic pv9, pv8;
    usps_top #(.BLINK_HALF_CYC(8)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .usb_state_in(usb),
        .cfg_sel_a_we_in(we_a), .cfg_sel_b_we_in(we_b), .cfg_sel_in(sel), .cfg_func_we_in(fwe),
        .cfg_func_idx_in(fidx), .cfg_func_in(fcode), .gpio_out_val_in(gval), .uart_rx_busy_in(rxb),
        .uart_tx_busy_in(txb), .uart_tx_active_in(txa), .flow_rts_assert_in(rts), .flow_dtr_assert_in(dtr),
        .pin_in(lvl), .pin_out(p_out), .pin_oe_out(p_oe), .pin_pullup_out(p_pu), .usb_condition_out_a(st_a),
        .usb_condition_out_b(st_b), .clear_send_out(cts), .set_ready_out(dsr), .carrier_detect_out(cd),
        .ring_indicate_out(ri), .gpio_in_val_out(gin), .remote_wakeup_req_out(wake));
    usps_peer peer (.dev_val_in(p_out), .dev_oe_in(p_oe), .dev_pu_in(p_pu), .low_in(low), .level_out(lvl));
    initial forever #4 core_clk_in = ~core_clk_in;
    always @(negedge core_clk_in) if (wake === 1'b1) nwake++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic setf(input int i, input logic [2:0] c);
        fidx = 4'(i);
        fcode = c;
        fwe = 1'b1;
        cyc(1);
        fwe = 1'b0;
        cyc(2);
    endtask
    task automatic complete_run;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic want(usps_cond_sel_t s, usps_usb_state_t u);
        logic hi_unsafe;
        hi_unsafe = (u.max_power > 8'h32) && !u.configured;
        return ((s[0] & u.bus_reset) | (s[1] & u.suspended) | (s[2] & (u.suspended | hi_unsafe))) ^ s[3];
    endfunction
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
    initial begin
        tab = '{'{1'b1, 1'b0, 1'b1, 8'h32}, '{1'b0, 1'b1, 1'b1, 8'h32}, '{1'b0, 1'b0, 1'b0, 8'h33},
            '{1'b0, 1'b0, 1'b0, 8'h32}, '{1'b0, 1'b0, 1'b1, 8'hfa}};
        cyc(5);
        rst_in = 1'b0;
        cyc(1);
        chk({st_a, st_b, p_oe, p_pu}, {2'b01, 10'h000, 10'h3ff});
        usb.suspended = 1'b1;
        cyc(2);
        chk({st_a, st_b}, 2'b10);
        for (int s = 0; s < 16; s++) begin
            sel = usps_cond_sel_t'(4'(s));
            we_a = 1'b1;
            we_b = 1'b1;
            cyc(1);
            we_a = 1'b0;
            we_b = 1'b0;
            for (int k = 0; k < 5; k++) begin
                usb = tab[k];
                cyc(3);
                chk({st_a, st_b}, {2{want(sel, tab[k])}});
            end
        end
        for (int i = 0; i < 10; i++) setf(i, 3'h2);
        rts = 1'b1;
        dtr = 1'b1;
        txa = 1'b1;
        low = 10'h017;
        cyc(5);
        chk({p_oe[5], p_out[5], p_oe[3], p_out[3], p_out[7], cts, dsr, cd, ri}, 9'h15f);
        chk(gin, 1'b0);
        rts = 1'b0;
        txa = 1'b0;
        low = 10'h000;
        cyc(5);
        chk({p_out[5], p_out[7], cts, dsr, cd, ri}, 6'h20);
        chk(nwake, 32'h0);
        chk(gin, 1'b1);
        setf(5, 3'h3);
        setf(0, 3'h3);
        txa = 1'b1;
        low[0] = 1'b1;
        cyc(10);
        chk(p_out[5], 1'b1);
        chk(nwake, 32'h1);
        chk(gin, 1'b0);
        setf(6, 3'h1);
        gval = 10'h040;
        rxb = 1'b1;
        txb = 1'b1;
        n9 = 0;
        n8 = 0;
        pv9 = p_out[9];
        pv8 = p_out[8];
        repeat (48) begin
            cyc(1);
            n9 += int'(p_out[9] != pv9);
            n8 += int'(p_out[8] != pv8);
            pv9 = p_out[9];
            pv8 = p_out[8];
        end
        chk(n9, 32'h5);
        chk(n8, 32'h5);
        chk({p_oe[6], p_out[6]}, 2'b11);
        rxb = 1'b0;
        txb = 1'b0;
        cyc(24);
        chk({p_oe[9:8], p_out[9:8]}, 4'hf);
        complete_run();
    end
endmodule
